// File: core/dsc_regs.svh
// Constants for the drive select and seek controller
// Summary of operation
// R1: Two-bit drive number, active-low select enable
// R2: Hold select low while selected; drive acknowledges
// R3: No ready within 2^16 clocks: selection fault
// R4: Fault after ready deselects, selection fault
// R5: Floppy mode timeout uses motor-on delay
// R6: Step mode seek pulses head-move output
// R7: Head direction shows travel of each pulse
// R8: Restore by step pulses or zero pulse
// R9: Hard mode: one step, wait low, rest, high
// R10: Seek complete dropping while selected: drive fault; code checks it only after a finished step seek in floppy or hard mode
// R11: First pulse unacknowledged in 2^16 clocks: seek error
// R12: Serial mode waits command complete before sending
// R13: Sixteen-bit serial word, per-bit request/acknowledge
// R14: After serial seek, wait or release for overlap
// R15: On track: select head, settle, then transfer
// R16: Sample write protect before write/format; abort
// R17: Write protect held low for hard disks
// R18: Modes: floppy, step hard disk, serial command
// R19: Direction set before first pulse, held stable
`ifndef DSC_REGS_SVH
`define DSC_REGS_SVH
`define DSC_SEL_TIMEOUT     32'h0001_0000
`define DSC_SEEK_TIMEOUT    32'h0001_0000
`define DSC_STEP_WIDTH_NS   32'h0000_03E8
`define DSC_SETUP_NS        32'h0000_03E8
`define DSC_CLK_NS          32'h0000_0064
`define DSC_CMD_BITS        5'h10
`define DSC_RESTORE_MAX     16'hFFFF
`endif

// File: core/dsc_pkg.sv
// Types for the drive select and seek controller
package dsc_pkg;
  typedef enum logic [1:0] {
    DSC_MODE_FLOPPY,
    DSC_MODE_HARD,
    DSC_MODE_SERIAL
  } dsc_mode_t;

  typedef enum logic [2:0] {
    DSC_ERR_NONE,
    DSC_ERR_SELECT,
    DSC_ERR_DRIVE,
    DSC_ERR_SEEK,
    DSC_ERR_PROTECT
  } dsc_err_t;
endpackage

// File: core/dsc_drive_ctrl.sv
// Drive selection, head positioning and write-protect check
`timescale 1ns/100ps
`include "dsc_regs.svh"
module dsc_drive_ctrl #(
  parameter int CNT_W       = 32,
  parameter int SEL_TIMEOUT = `DSC_SEL_TIMEOUT,
  parameter int SEEK_TIMEOUT = `DSC_SEEK_TIMEOUT
) (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Configuration
  input  wire dsc_pkg::dsc_mode_t mode_i,
  input  wire logic [CNT_W-1:0]  motor_on_delay_i,
  input  wire logic [CNT_W-1:0]  step_interval_i,
  input  wire logic [CNT_W-1:0]  head_settle_i,
  input  wire logic              restore_by_rtz_i,
  // Command
  input  wire logic              cmd_start_i,
  input  wire logic              cmd_release_i,
  input  wire logic [1:0]        cmd_drive_i,
  input  wire logic              cmd_seek_i,
  input  wire logic              cmd_restore_i,
  input  wire logic              cmd_write_i,
  input  wire logic              cmd_dir_i,
  input  wire logic [15:0]       cmd_steps_i,
  input  wire logic [15:0]       cmd_word_i,
  input  wire logic              cmd_overlap_i,
  input  wire logic [3:0]        cmd_head_i,
  output logic                   busy_o,
  output logic                   done_o,
  output logic                   xfer_go_o,
  output dsc_pkg::dsc_err_t      error_o,
  // Drive cable
  output logic                   drive_select_enable_n_o,
  output logic [1:0]             drive_number_select_o,
  output logic [3:0]             head_select_o,
  input  wire logic              drive_ready_ack_n_i,
  input  wire logic              fault_i,
  output logic                   step_o,
  output logic                   head_direction_o,
  output logic                   return_to_zero_pulse_o,
  input  wire logic              seek_complete_i,
  input  wire logic              track_zero_indicator_i,
  input  wire logic              write_protect_i,
  // Serial command link
  input  wire logic              command_complete_i,
  output logic                   xfer_request_o,
  output logic                   xfer_data_o,
  input  wire logic              xfer_ack_i
);
  localparam logic [CNT_W-1:0] STEP_W =
    CNT_W'((`DSC_STEP_WIDTH_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS);
  localparam logic [CNT_W-1:0] SETUP_W =
    CNT_W'((`DSC_SETUP_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS);

  // Refuse counter widths and timeouts the sequencer cannot serve
  if (CNT_W < 17 || CNT_W > 32) begin : g_bad_cnt_w
    $error("CNT_W out of range");
  end
  if (SEL_TIMEOUT < 2 || SEEK_TIMEOUT < 2) begin : g_bad_timeout
    $error("timeout parameters too small");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_SELECT, S_DIR, S_PULSE, S_WAIT_LO, S_GAP, S_WAIT_HI,
    S_SER_WAIT, S_SER_BIT, S_SER_ACK, S_SETTLE, S_ON
  } dsc_state_t;

  dsc_state_t        state;
  logic [CNT_W-1:0]  cnt;
  logic [15:0]       steps;
  logic [15:0]       shreg;
  logic [4:0]        bit_cnt;
  logic              first;
  logic              seeking;
  logic              write_cmd;
  logic              tracking;

  function automatic logic expired(input logic [CNT_W-1:0] c, input logic [CNT_W-1:0] lim);
    expired = (c >= lim - CNT_W'(1));
  endfunction

  wire logic ready = !drive_ready_ack_n_i;
  wire logic [CNT_W-1:0] sel_lim = (mode_i == dsc_pkg::DSC_MODE_FLOPPY) ?
                                   motor_on_delay_i : CNT_W'(SEL_TIMEOUT); // [R5] [R3]

  //----------------------------------------------------------------------
  // Sequencer
  //----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state                   <= S_IDLE;
      cnt                     <= '0;
      steps                   <= 16'h0000;
      shreg                   <= 16'h0000;
      bit_cnt                 <= 5'h00;
      first                   <= 1'b0;
      seeking                 <= 1'b0;
      write_cmd               <= 1'b0;
      tracking                <= 1'b0;
      drive_select_enable_n_o <= 1'b1;
      drive_number_select_o   <= 2'h0;
      head_select_o           <= 4'h0;
      step_o                  <= 1'b0;
      head_direction_o        <= 1'b0;
      return_to_zero_pulse_o  <= 1'b0;
      xfer_request_o          <= 1'b0;
      xfer_data_o             <= 1'b0;
      error_o                 <= dsc_pkg::DSC_ERR_NONE;
      done_o                  <= 1'b0;
      xfer_go_o               <= 1'b0;
    end else begin
      done_o    <= 1'b0;
      xfer_go_o <= 1'b0;
      cnt       <= cnt + CNT_W'(1);
      // In floppy and hard modes a selected drive must keep seek complete high after a finished step seek
      if (tracking && !drive_select_enable_n_o && ready && !seeking && !seek_complete_i &&
          mode_i != dsc_pkg::DSC_MODE_SERIAL) begin
        state                   <= S_IDLE; // [R10]
        error_o                 <= dsc_pkg::DSC_ERR_DRIVE;
        drive_select_enable_n_o <= 1'b1;
        tracking                <= 1'b0;
        done_o                  <= 1'b1;
      end else if (state != S_IDLE && state != S_SELECT && fault_i) begin
        state                   <= S_IDLE; // [R4]
        error_o                 <= dsc_pkg::DSC_ERR_SELECT;
        drive_select_enable_n_o <= 1'b1;
        step_o                  <= 1'b0;
        return_to_zero_pulse_o  <= 1'b0;
        xfer_request_o          <= 1'b0;
        tracking                <= 1'b0;
        done_o                  <= 1'b1;
      end else begin
        unique case (state)
          S_IDLE: begin
            if (cmd_release_i) begin
              drive_select_enable_n_o <= 1'b1;
              tracking                <= 1'b0;
            end else if (cmd_start_i) begin
              if (drive_select_enable_n_o || drive_number_select_o != cmd_drive_i) begin
                tracking <= 1'b0;
              end
              drive_select_enable_n_o <= 1'b0; // [R1] [R2]
              drive_number_select_o   <= cmd_drive_i;
              head_select_o           <= cmd_head_i;
              seeking                 <= cmd_seek_i || cmd_restore_i;
              write_cmd               <= cmd_write_i;
              steps                   <= cmd_steps_i;
              shreg                   <= cmd_word_i;
              error_o                 <= dsc_pkg::DSC_ERR_NONE;
              cnt                     <= '0;
              state                   <= S_SELECT;
            end
          end
          S_SELECT: begin
            if (ready) begin
              cnt <= '0;
              if (!seeking) begin
                state <= S_SETTLE;
              end else if (mode_i == dsc_pkg::DSC_MODE_SERIAL) begin // [R18]
                state <= S_SER_WAIT;
              end else begin
                head_direction_o <= cmd_restore_i ? 1'b0 : cmd_dir_i; // [R7] [R19]
                first            <= 1'b1;
                if (cmd_restore_i && !restore_by_rtz_i) begin
                  steps <= `DSC_RESTORE_MAX; // [R8]
                end
                state <= S_DIR;
              end
            end else if (expired(cnt, sel_lim)) begin
              state                   <= S_IDLE; // [R3] [R5]
              error_o                 <= dsc_pkg::DSC_ERR_SELECT;
              drive_select_enable_n_o <= 1'b1;
              done_o                  <= 1'b1;
            end
          end
          S_DIR: begin
            if (expired(cnt, SETUP_W)) begin
              cnt <= '0;
              if (cmd_restore_i && restore_by_rtz_i) begin
                return_to_zero_pulse_o <= 1'b1; // [R8]
              end else if (steps == 16'h0000) begin
                seeking <= 1'b0;
                state   <= S_SETTLE;
              end else begin
                step_o <= 1'b1; // [R6]
                steps  <= steps - 16'h0001;
              end
              if (!(steps == 16'h0000 && !(cmd_restore_i && restore_by_rtz_i))) begin
                state <= S_PULSE;
              end
            end
          end
          S_PULSE: begin
            if (expired(cnt, STEP_W)) begin
              step_o                 <= 1'b0;
              return_to_zero_pulse_o <= 1'b0;
              cnt                    <= '0;
              state                  <= first ? S_WAIT_LO : S_GAP;
            end
          end
          S_WAIT_LO: begin
            if (!seek_complete_i) begin
              first <= 1'b0; // [R9] [R11]
              cnt   <= '0;
              state <= S_GAP;
            end else if (expired(cnt, CNT_W'(SEEK_TIMEOUT))) begin
              state   <= S_IDLE; // [R11]
              error_o <= dsc_pkg::DSC_ERR_SEEK;
              done_o  <= 1'b1;
            end
          end
          S_GAP: begin
            if (cmd_restore_i && !restore_by_rtz_i && track_zero_indicator_i) begin
              steps <= 16'h0000;
            end
            if (steps == 16'h0000 || (cmd_restore_i && restore_by_rtz_i) ||
                (cmd_restore_i && track_zero_indicator_i)) begin
              cnt   <= '0;
              state <= S_WAIT_HI;
            end else if (expired(cnt, step_interval_i)) begin
              step_o <= 1'b1; // [R6] [R9]
              steps  <= steps - 16'h0001;
              cnt    <= '0;
              state  <= S_PULSE;
            end
          end
          S_WAIT_HI: begin
            if (seek_complete_i) begin
              seeking  <= 1'b0; // [R9]
              tracking <= 1'b1;
              cnt      <= '0;
              state    <= S_SETTLE;
            end
          end
          S_SER_WAIT: begin
            if (command_complete_i) begin
              bit_cnt <= 5'h00; // [R12]
              state   <= S_SER_BIT;
            end
          end
          S_SER_BIT: begin
            if (!xfer_ack_i) begin
              xfer_data_o    <= shreg[15]; // [R13]
              xfer_request_o <= 1'b1;
              state          <= S_SER_ACK;
            end
          end
          S_SER_ACK: begin
            if (xfer_ack_i) begin
              xfer_request_o <= 1'b0; // [R13]
              shreg          <= {shreg[14:0], 1'b0};
              bit_cnt        <= bit_cnt + 5'h01;
              if (bit_cnt == `DSC_CMD_BITS - 5'h01) begin
                seeking <= 1'b0;
                cnt     <= '0;
                if (cmd_overlap_i) begin
                  state  <= S_IDLE; // [R14]
                  done_o <= 1'b1;
                end else begin
                  state <= S_SETTLE;
                end
              end else begin
                state <= S_SER_BIT;
              end
            end
          end
          S_SETTLE: begin
            if (mode_i == dsc_pkg::DSC_MODE_SERIAL && !command_complete_i) begin
              cnt <= '0; // [R15]
            end else if (expired(cnt, head_settle_i)) begin
              state <= S_ON;
            end
          end
          S_ON: begin
            if (write_cmd && write_protect_i) begin
              error_o <= dsc_pkg::DSC_ERR_PROTECT; // [R16]
              done_o  <= 1'b1;
              state   <= S_IDLE;
            end else if (mode_i != dsc_pkg::DSC_MODE_SERIAL || command_complete_i) begin
              xfer_go_o <= 1'b1; // [R15]
              done_o    <= 1'b1;
              state     <= S_IDLE;
            end
          end
        endcase
      end
    end
  end

  assign busy_o = (state != S_IDLE);

  //----------------------------------------------------------------------
  // Checks
  //----------------------------------------------------------------------
  sequence seq_first_pulse;
    step_o && first;
  endsequence
  sequence seq_sc_lost;
    tracking && !drive_select_enable_n_o && ready && !seeking && !seek_complete_i &&
    mode_i != dsc_pkg::DSC_MODE_SERIAL;
  endsequence

  AST_SEL_IDLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R1]
    (state == S_SELECT) |-> !drive_select_enable_n_o)
    else $error("select enable high while selecting");
  AST_SEL_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R2]
    (state == S_PULSE) |-> !drive_select_enable_n_o && $stable(drive_number_select_o))
    else $error("drive changed during seek");
  AST_FAULT_DESEL: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R4]
    (busy_o && state != S_SELECT && fault_i && !(tracking && ready && !seeking &&
     !seek_complete_i && mode_i != dsc_pkg::DSC_MODE_SERIAL))
    |=> drive_select_enable_n_o && error_o == dsc_pkg::DSC_ERR_SELECT)
    else $error("fault did not deselect");
  AST_DIR_STABLE: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R19] [R7]
    (step_o || state == S_GAP) |-> $stable(head_direction_o))
    else $error("direction moved during seek");
  AST_FIRST_WAIT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R9]
    seq_first_pulse ##1 !step_o |-> state == S_WAIT_LO)
    else $error("first pulse not followed by wait");
  AST_SEEK_TO: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R11]
    (state == S_WAIT_LO && seek_complete_i && expired(cnt, CNT_W'(SEEK_TIMEOUT)) &&
     !fault_i && !(tracking && ready && !seeking && !seek_complete_i))
    |=> error_o == dsc_pkg::DSC_ERR_SEEK && !busy_o)
    else $error("seek timeout not reported");
  AST_SER_START: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R12] [R13]
    $rose(xfer_request_o) |-> $past(state) == S_SER_BIT)
    else $error("request outside bit phase");
  AST_SER_HS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R13]
    (xfer_request_o && !xfer_ack_i && !fault_i) |=> xfer_request_o && $stable(xfer_data_o))
    else $error("request dropped before acknowledge");
  AST_WP_ABORT: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R16]
    (state == S_ON && write_cmd && write_protect_i && !fault_i &&
     !(tracking && ready && !seeking && !seek_complete_i && mode_i != dsc_pkg::DSC_MODE_SERIAL))
    |=> !xfer_go_o && error_o == dsc_pkg::DSC_ERR_PROTECT)
    else $error("write not aborted on protect");
  AST_GO_CC: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R15]
    (xfer_go_o && mode_i == dsc_pkg::DSC_MODE_SERIAL) |-> $past(command_complete_i))
    else $error("transfer started without command complete");
  AST_SC_LOSS: assert property (@(posedge clk_i) disable iff (!reset_n_i) // [R10]
    seq_sc_lost |=> drive_select_enable_n_o && error_o == dsc_pkg::DSC_ERR_DRIVE)
    else $error("seek complete loss not reported");
endmodule

// File: verif/dsc_drive_model.sv
// Behavioural disk drive on the far side of the control cable
`timescale 1ns/100ps
module dsc_drive_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  // Cable from the controller
  input  wire logic        sel_n_i,
  input  wire logic        step_i,
  input  wire logic        dir_i,
  input  wire logic        rtz_i,
  input  wire logic        req_i,
  input  wire logic        data_i,
  // Bench controls
  input  wire logic        present_i,
  input  wire logic        respond_i,
  input  wire logic        sc_drop_i,
  input  wire logic        cc_hold_i,
  // Cable to the controller
  output logic             ready_n_o,
  output logic             sc_o,
  output logic             cc_o,
  output logic             ack_o,
  output logic             tz_o,
  output logic [15:0]      word_o
);
  logic [7:0] busy_cnt;
  logic [4:0] bits;
  logic       step_q;
  logic       rtz_q;
  logic       trig;
  logic [3:0] pos;
  assign trig = respond_i && ((step_i && !step_q) || (rtz_i && !rtz_q) || bits == 5'h10);
  assign sc_o = (busy_cnt == 8'h00) && !sc_drop_i;
  assign cc_o = sc_o && !cc_hold_i;
  assign tz_o = (pos == 4'h0);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ready_n_o <= 1'b1;
      busy_cnt  <= 8'h00;
      bits      <= 5'h00;
      step_q    <= 1'b0;
      rtz_q     <= 1'b0;
      ack_o     <= 1'b0;
      pos       <= 4'h0;
      word_o    <= 16'h0000;
    end else begin
      ready_n_o <= !(present_i && !sel_n_i);
      step_q    <= step_i;
      rtz_q     <= rtz_i;
      if (trig) begin
        busy_cnt <= 8'h28;
      end else if (busy_cnt != 8'h00) begin
        busy_cnt <= busy_cnt - 8'h01;
      end
      // Head position: inward steps count up, outward steps down to track zero
      if (rtz_i && !rtz_q) begin
        pos <= 4'h0;
      end else if (step_i && !step_q && dir_i) begin
        pos <= pos + 4'h1;
      end else if (step_i && !step_q && pos != 4'h0) begin
        pos <= pos - 4'h1;
      end
      if (bits == 5'h10) begin
        bits <= 5'h00;
      end else if (req_i && !ack_o) begin
        ack_o  <= 1'b1;
        word_o <= {word_o[14:0], data_i};
        bits   <= bits + 5'h01;
      end else if (!req_i && ack_o) begin
        ack_o <= 1'b0;
      end
    end
  end
endmodule

// File: verif/dsc_drive_ctrl_tb.sv
// Self-checking bench for the drive select and seek controller
`timescale 1ns/100ps
module dsc_drive_ctrl_tb;
  logic clk_i, reset_n_i, rtz_en, start, release_p, drv_ready_n, fault_i, wp;
  logic seek, rest, wr, dir, busy_o, done_o, go_o, sel_n, step_o, dir_o, rtz_o;
  logic req, xdat, ack, sc, cc, tz, present, respond, sc_drop, cc_hold, ovl;
  logic [1:0] drv, drv_num;
  logic [3:0] head_sel, head;
  logic [15:0] steps, word, got;
  dsc_pkg::dsc_mode_t mode;
  dsc_pkg::dsc_err_t  err;
  int bad_count, n_compared, n_step, n_rtz, n_go, n_done, bad_dir, dur, cyc;

  dsc_drive_ctrl #(.SEL_TIMEOUT(64), .SEEK_TIMEOUT(64)) DUT (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .mode_i(mode), .motor_on_delay_i(32'h0000_0014),
    .step_interval_i(32'h0000_0014), .head_settle_i(32'h0000_0005),
    .restore_by_rtz_i(rtz_en), .cmd_start_i(start), .cmd_release_i(release_p),
    .cmd_drive_i(drv), .cmd_seek_i(seek), .cmd_restore_i(rest), .cmd_write_i(wr),
    .cmd_dir_i(dir), .cmd_steps_i(steps), .cmd_word_i(word), .cmd_overlap_i(ovl),
    .cmd_head_i(head), .busy_o(busy_o), .done_o(done_o), .xfer_go_o(go_o), .error_o(err),
    .drive_select_enable_n_o(sel_n), .drive_number_select_o(drv_num),
    .head_select_o(head_sel), .drive_ready_ack_n_i(drv_ready_n), .fault_i(fault_i),
    .step_o(step_o), .head_direction_o(dir_o), .return_to_zero_pulse_o(rtz_o),
    .seek_complete_i(sc), .track_zero_indicator_i(tz), .write_protect_i(wp),
    .command_complete_i(cc), .xfer_request_o(req), .xfer_data_o(xdat), .xfer_ack_i(ack));

  dsc_drive_model MDL (.clk_i(clk_i), .reset_n_i(reset_n_i), .sel_n_i(sel_n),
    .step_i(step_o), .dir_i(dir_o), .rtz_i(rtz_o), .req_i(req), .data_i(xdat),
    .present_i(present),
    .respond_i(respond), .sc_drop_i(sc_drop), .cc_hold_i(cc_hold), .ready_n_o(drv_ready_n),
    .sc_o(sc), .cc_o(cc), .ack_o(ack), .tz_o(tz), .word_o(got));

  // ----------------------------------------
  // Clock, watchdog and pulse monitors
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (go_o === 1'b1) n_go++;
    if (done_o === 1'b1) n_done++;
    if (cyc == 40000) begin
      bad_count++;
      stop_test();
    end
  end
  always @(posedge rtz_o) n_rtz++;
  always @(posedge step_o) begin
    n_step++;
    if (dir_o !== dir || sel_n !== 1'b0 || drv_num !== drv) bad_dir++;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic begin_cmd(input logic [1:0] d, input logic s, r, w, dr,
                           input logic [15:0] n);
    drv = d; seek = s; rest = r; wr = w; dir = dr; steps = n;
    n_step = 0; n_rtz = 0; n_go = 0; n_done = 0; bad_dir = 0;
    start = 1'b1;
    tick(1);
    start = 1'b0;
  endtask
  task automatic wait_idle();
    dur = 1;
    while (busy_o !== 1'b0 && dur < 3000) begin
      tick(1);
      dur++;
    end
    if (busy_o !== 1'b0) bad_count++;
    tick(1);
  endtask
  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic hard_seek_then_loss();
    mode = dsc_pkg::DSC_MODE_HARD;
    begin_cmd(2'h2, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0003);
    wait_idle();
    check(n_step, 3);
    check(bad_dir, 0);
    check({sel_n, drv_num, head_sel}, {1'b0, 2'h2, 4'h5});
    check(n_go, 1);
    check(16'(err), 16'(dsc_pkg::DSC_ERR_NONE));
    sc_drop = 1'b1;
    tick(20);
    sc_drop = 1'b0;
    check(16'(err), 16'(dsc_pkg::DSC_ERR_DRIVE));
    check(sel_n, 1'b1);
  endtask
  task automatic fault_after_ready();
    begin_cmd(2'h1, 1'b1, 1'b0, 1'b0, 1'b0, 16'h000A);
    tick(30);
    fault_i = 1'b1;
    wait_idle();
    fault_i = 1'b0;
    check(16'(err), 16'(dsc_pkg::DSC_ERR_SELECT));
    check(sel_n, 1'b1);
  endtask
  task automatic absent_drive(input dsc_pkg::dsc_mode_t m, input int lo, input int hi);
    mode = m;
    present = 1'b0;
    begin_cmd(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0001);
    wait_idle();
    present = 1'b1;
    check(16'(err), 16'(dsc_pkg::DSC_ERR_SELECT));
    check(dur >= lo && dur <= hi, 1'b1);
    check(n_step, 0);
    check(16'(n_done), 16'h0001);
  endtask
  task automatic floppy_seek_and_silent_drive();
    mode = dsc_pkg::DSC_MODE_FLOPPY;
    begin_cmd(2'h0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0002);
    wait_idle();
    check(n_step, 2);
    mode = dsc_pkg::DSC_MODE_HARD;
    respond = 1'b0;
    begin_cmd(2'h0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0002);
    wait_idle();
    respond = 1'b1;
    check(16'(err), 16'(dsc_pkg::DSC_ERR_SEEK));
  endtask
  task automatic restore_rtz();
    rtz_en = 1'b1;
    begin_cmd(2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    wait_idle();
    check(16'(n_rtz), 16'h0001);
    check(16'(n_step), 16'h0000);
    check(16'(err), 16'(dsc_pkg::DSC_ERR_NONE));
    rtz_en = 1'b0;
    begin_cmd(2'h1, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0003);
    wait_idle();
    begin_cmd(2'h1, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    wait_idle();
    check(16'(n_step), 16'h0003);
    check(16'(n_rtz) + 16'(bad_dir), 16'h0000);
    check(16'(err), 16'(dsc_pkg::DSC_ERR_NONE));
  endtask
  task automatic write_protect();
    wp = 1'b1;
    begin_cmd(2'h2, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0001);
    wait_idle();
    wp = 1'b0;
    check(16'(err), 16'(dsc_pkg::DSC_ERR_PROTECT));
    check(n_go, 0);
    begin_cmd(2'h2, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0001);
    wait_idle();
    check(16'(n_go), 16'h0001);
    check(16'(err), 16'(dsc_pkg::DSC_ERR_NONE));
    release_p = 1'b1;
    tick(1);
    release_p = 1'b0;
    tick(2);
    check(sel_n, 1'b1);
  endtask
  task automatic serial_seek();
    mode = dsc_pkg::DSC_MODE_SERIAL;
    word = 16'hA5C3;
    head = 4'hA;
    cc_hold = 1'b1;
    begin_cmd(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    tick(30);
    check(req, 1'b0);
    cc_hold = 1'b0;
    wait_idle();
    check(got, 16'hA5C3);
    check(n_go, 1);
    check(16'(head_sel), 16'h000A);
    check(16'(err), 16'(dsc_pkg::DSC_ERR_NONE));
    ovl = 1'b1;
    word = 16'h3C5A;
    begin_cmd(2'h3, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0000);
    wait_idle();
    ovl = 1'b0;
    check(got, 16'h3C5A);
    check(16'(n_go), 16'h0000);
    check(16'(n_done), 16'h0001);
    check(sel_n, 1'b0);
  endtask

  initial begin
    reset_n_i = 1'b0; mode = dsc_pkg::DSC_MODE_HARD; rtz_en = 1'b0; start = 1'b0;
    release_p = 1'b0; drv = 2'h0; seek = 1'b0; rest = 1'b0; wr = 1'b0; dir = 1'b0;
    steps = 16'h0000; word = 16'h0000; fault_i = 1'b0;
    wp = 1'b0;
    present = 1'b1; respond = 1'b1; sc_drop = 1'b0; cc_hold = 1'b0;
    head = 4'h5; ovl = 1'b0;
    bad_count = 0; n_compared = 0; cyc = 0;
    tick(12);
    reset_n_i = 1'b1;
    hard_seek_then_loss();
    fault_after_ready();
    absent_drive(dsc_pkg::DSC_MODE_HARD, 64, 72);
    absent_drive(dsc_pkg::DSC_MODE_FLOPPY, 20, 30);
    floppy_seek_and_silent_drive();
    restore_rtz();
    write_protect();
    serial_seek();
    stop_test();
  end
endmodule
